// ==== fesp_edge.sv ====
// falling-edge detector for a group of level signals
// assumes the levels are synchronous to pclk
`timescale 1ns/100ps
`default_nettype none
module fesp_edge
	import fesp_pkg::*;
#(
	parameter int W = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic [W-1:0] lvl,
	output logic [W-1:0] fall
);
	typedef struct packed {
		logic [W-1:0] prev;
	} fesp_edge_st_t;

	fesp_edge_st_t s;
	fesp_edge_st_t next_s;

	// previous level is the only state
	always_comb begin
		next_s = s;
		next_s.prev = lvl;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else if (clk_en) begin
			s <= next_s;
		end
	end

	// a pulse only while the enable lets state move, so one end gives one pulse
	assign fall = s.prev & ~lvl & {W{clk_en}};
endmodule
`default_nettype wire

// ==== fesp_host.sv ====
// host read-cycle model: frames one status read per start pulse
// assumes start is a one-cycle pulse from the bench, synchronous to pclk
`timescale 1ns/100ps
`default_nettype none
module fesp_host (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire logic use_ce,
	output logic chip_enable_n,
	output logic output_enable_n,
	output logic done
);
	logic [1:0] cnt;
	// read held two cycles; only the framing strobe rises, the other stays low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 2'h0;
			chip_enable_n <= 1'b1;
			output_enable_n <= 1'b1;
			done <= 1'b0;
		end else begin
			done <= (cnt == 2'h1);
			if (start) begin
				cnt <= 2'h2;
				chip_enable_n <= 1'b0;
				output_enable_n <= 1'b0;
			end else if (cnt != 2'h0) begin
				cnt <= cnt - 2'h1;
			end
			if (cnt == 2'h1 && use_ce) begin
				chip_enable_n <= 1'b1;
			end
			if (cnt == 2'h1 && !use_ce) begin
				output_enable_n <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ==== fesp_pkg.sv ====
// constants, types and carriers for the status-polling block
// assumes a single 200 MHz clock domain and an apb register port
package fesp_pkg;

	// clock and timing
	localparam int CLK_MHZ = 200;
	localparam int PROT_TIME_US = 100;
	localparam int PROT_CYC_DEF = PROT_TIME_US * CLK_MHZ;
	localparam int RST_BUSY_US = 2;
	localparam int RST_BUSY_CYC = RST_BUSY_US * CLK_MHZ;
	localparam int CNT_W = 15;

	// apb register map, byte addresses
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] ADDR_CMD = 12'h000;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h004;

	// command register fields
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_OP_W = 4;
	localparam int CMD_PROT_BIT = 8;

	// command codes written by the embedded algorithm controller
	localparam logic [3:0] OP_PROG = 4'h1;
	localparam logic [3:0] OP_ERASE = 4'h2;
	localparam logic [3:0] OP_BUF = 4'h3;
	localparam logic [3:0] OP_SUSP = 4'h4;
	localparam logic [3:0] OP_RESUME = 4'h5;
	localparam logic [3:0] OP_RESET = 4'h6;
	localparam logic [3:0] OP_ABRST = 4'h7;
	localparam logic [3:0] OP_DONE = 4'h8;
	localparam logic [3:0] OP_TIMEOUT = 4'h9;
	localparam logic [3:0] OP_ABORT = 4'hA;

	// status word bit positions on the data bus
	localparam int DQ_POLL = 7;
	localparam int DQ_TOG1 = 6;
	localparam int DQ_TMO = 5;
	localparam int DQ_ESTART = 3;
	localparam int DQ_TOG2 = 2;
	localparam int DQ_ABORT = 1;

	// status register fields
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_TOG1_BIT = 1;
	localparam int ST_TOG2_BIT = 2;
	localparam int ST_ESTART_BIT = 3;
	localparam int ST_ABORT_BIT = 4;
	localparam int ST_TMO_BIT = 5;
	localparam int ST_MODE_LSB = 8;

	// reset values
	localparam logic [15:0] DOUT_RST = 16'h0000;
	localparam logic [31:0] PRDATA_RST = 32'h0000_0000;
	localparam logic [CNT_W-1:0] CNT_RST = 15'h0000;

	typedef enum logic [3:0] {
		M_IDLE, M_PROG, M_BUF, M_ERASE, M_PROT, M_ESUSP, M_ESPROG, M_PSUSP, M_RSTBUSY
	} fesp_mode_t;

	// flash-side pins, all synchronous to pclk
	typedef struct packed {
		logic chip_enable_n;
		logic output_enable_n;
		logic write_strobe_n;
		logic in_erase_sector;
		logic [15:0] array_data;
		logic prog_data7;
	} fesp_pins_t;

	// apb request from the master
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
	} fesp_apb_req_t;

	// apb answer to the master
	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} fesp_apb_rsp_t;

endpackage

// ==== fesp_top.sv ====
// status-polling overlay of a parallel nor flash during embedded operations
// assumes pins are synchronous to pclk and the controller talks over apb
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
module fesp_top
	import fesp_pkg::*;
#(
	parameter int PROT_CYCLES = PROT_CYC_DEF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire fesp_apb_req_t apb_req,
	output fesp_apb_rsp_t apb_rsp,
	input wire fesp_pins_t pins,
	output logic [15:0] data_out,
	output logic status_overlay,
	output logic ready_busy_n
);
	typedef struct packed {
		fesp_mode_t mode;
		logic from_buf;
		logic timeout_flag;
		logic buffer_abort_flag;
		logic toggle_bit_one;
		logic sector_toggle_bit;
		logic [CNT_W-1:0] cnt;
		logic [15:0] dout;
		logic overlay;
		logic rb_n;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} fesp_st_t;

	fesp_st_t s;
	fesp_st_t next_s;
	logic read_active;
	logic rd_end;
	logic cmd_we;
	logic [3:0] op;
	logic prot;
	logic toggling;
	logic busy;
	logic [31:0] status_reg;
	logic poll_bit;
	logic estart;

	// a read cycle is framed by either strobe; its end is either rising
	assign read_active = !pins.chip_enable_n && !pins.output_enable_n && pins.write_strobe_n;

	fesp_edge #(
		.W(1)
	) u_rd_edge (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.lvl(read_active),
		.fall(rd_end)
	);

	// commands take effect at the edge where the master sees pready
	assign cmd_we = apb_req.psel && apb_req.penable && s.pready && apb_req.pwrite
		&& (apb_req.paddr == ADDR_CMD);
	assign op = apb_req.pwdata[CMD_OP_LSB +: CMD_OP_W];
	assign prot = apb_req.pwdata[CMD_PROT_BIT];

	// modes in which toggle bit one moves
	assign toggling = (s.mode == M_PROG) || (s.mode == M_BUF) || (s.mode == M_ERASE)
		|| (s.mode == M_PROT) || (s.mode == M_ESPROG);
	assign busy = toggling || (s.mode == M_RSTBUSY);

	// software view of the block state
	always_comb begin
		status_reg = PRDATA_RST;
		status_reg[ST_BUSY_BIT] = busy;
		status_reg[ST_TOG1_BIT] = s.toggle_bit_one;
		status_reg[ST_TOG2_BIT] = s.sector_toggle_bit;
		status_reg[ST_ESTART_BIT] = (s.mode == M_ERASE) || (s.mode == M_ESUSP);
		status_reg[ST_ABORT_BIT] = s.buffer_abort_flag;
		status_reg[ST_TMO_BIT] = s.timeout_flag;
		status_reg[ST_MODE_LSB +: 4] = s.mode;
	end

	// next state: apb slave, mode sequencing, toggles and the data bus word
	always_comb begin
		next_s = s;
		poll_bit = 1'b0;
		estart = 1'b0;
		// one wait state per access; unmapped addresses answer with pslverr
		next_s.pready = 1'b0;
		next_s.pslverr = 1'b0;
		if (apb_req.psel && apb_req.penable && !s.pready) begin
			next_s.pready = 1'b1;
			next_s.pslverr = (apb_req.paddr != ADDR_CMD) && (apb_req.paddr != ADDR_STATUS);
			next_s.prdata = (apb_req.paddr == ADDR_STATUS && !apb_req.pwrite) ?
				status_reg : PRDATA_RST;
		end
		// mode sequencing; toggling starts as soon as the command lands
		case (s.mode)
			M_IDLE: begin
				if (cmd_we && op == OP_PROG) begin
					next_s.mode = M_PROG;
				end else if (cmd_we && op == OP_BUF) begin
					next_s.mode = M_BUF;
				end else if (cmd_we && op == OP_ERASE && prot) begin
					next_s.mode = M_PROT;
					next_s.cnt = CNT_W'(PROT_CYCLES - 1);
				end else if (cmd_we && op == OP_ERASE) begin
					next_s.mode = M_ERASE;
				end
			end
			M_PROG, M_BUF, M_ESPROG: begin
				if (cmd_we && op == OP_TIMEOUT) begin
					next_s.timeout_flag = 1'b1;
				end else if (cmd_we && op == OP_ABORT && s.mode == M_BUF) begin
					next_s.buffer_abort_flag = 1'b1;
				end else if (cmd_we && op == OP_RESET && s.timeout_flag) begin
					next_s.timeout_flag = 1'b0;
					next_s.mode = M_RSTBUSY;
					next_s.cnt = CNT_W'(RST_BUSY_CYC - 1);
				end else if (cmd_we && op == OP_ABRST && s.buffer_abort_flag) begin
					next_s.buffer_abort_flag = 1'b0;
					next_s.timeout_flag = 1'b0;
					next_s.mode = M_IDLE;
				end else if (s.timeout_flag || s.buffer_abort_flag) begin
					// failed operation stays busy until cleared
					next_s.mode = s.mode;
				end else if (cmd_we && op == OP_DONE) begin
					next_s.mode = (s.mode == M_ESPROG) ? M_ESUSP : M_IDLE;
				end else if (cmd_we && op == OP_SUSP && s.mode != M_ESPROG) begin
					next_s.from_buf = (s.mode == M_BUF);
					next_s.mode = M_PSUSP;
				end
			end
			M_ERASE: begin
				// only timeout, reset after a timeout, suspend and done are taken once erase runs
				if (cmd_we && op == OP_TIMEOUT) begin
					next_s.timeout_flag = 1'b1;
				end else if (cmd_we && op == OP_RESET && s.timeout_flag) begin
					next_s.timeout_flag = 1'b0;
					next_s.mode = M_RSTBUSY;
					next_s.cnt = CNT_W'(RST_BUSY_CYC - 1);
				end else if (cmd_we && op == OP_SUSP && !s.timeout_flag) begin
					next_s.mode = M_ESUSP;
				end else if (cmd_we && op == OP_DONE && !s.timeout_flag) begin
					next_s.mode = M_IDLE;
				end
			end
			M_PROT: begin
				// no erase happens; the countdown alone ends the busy spell
				if (s.cnt == CNT_RST) begin
					next_s.mode = M_IDLE;
				end else begin
					next_s.cnt = s.cnt - 1'b1;
				end
			end
			M_ESUSP: begin
				if (cmd_we && op == OP_RESUME) begin
					next_s.mode = M_ERASE;
				end else if (cmd_we && (op == OP_PROG || op == OP_BUF)) begin
					next_s.mode = M_ESPROG;
				end
			end
			M_PSUSP: begin
				if (cmd_we && op == OP_RESUME) begin
					next_s.mode = s.from_buf ? M_BUF : M_PROG;
				end
			end
			M_RSTBUSY: begin
				// busy may linger after reset; bounded by the count
				if (s.cnt == CNT_RST) begin
					next_s.mode = M_IDLE;
				end else begin
					next_s.cnt = s.cnt - 1'b1;
				end
			end
			default: begin
				next_s.mode = M_IDLE;
			end
		endcase
		// toggles move once per finished read cycle
		if (rd_end && toggling) begin
			next_s.toggle_bit_one = ~s.toggle_bit_one;
		end
		if (rd_end && pins.in_erase_sector && (s.mode == M_ERASE || s.mode == M_ESUSP)) begin
			next_s.sector_toggle_bit = ~s.sector_toggle_bit;
		end
		// poll bit and erase-started value for the coming mode
		case (next_s.mode)
			M_PROG, M_BUF, M_ESPROG: begin
				poll_bit = ~pins.prog_data7;
			end
			M_ESUSP: begin
				poll_bit = 1'b1;
				estart = 1'b1;
			end
			M_ERASE: begin
				estart = 1'b1;
			end
			default: begin
				poll_bit = 1'b0;
			end
		endcase
		// overlay everywhere while busy; suspend shows array outside its sector
		next_s.overlay = (next_s.mode == M_PROG) || (next_s.mode == M_BUF)
			|| (next_s.mode == M_ERASE) || (next_s.mode == M_PROT)
			|| (next_s.mode == M_ESPROG) || (next_s.mode == M_RSTBUSY)
			|| (next_s.mode == M_ESUSP && pins.in_erase_sector);
		if (next_s.overlay) begin
			next_s.dout = DOUT_RST;
			next_s.dout[DQ_POLL] = poll_bit;
			next_s.dout[DQ_TOG1] = next_s.toggle_bit_one;
			next_s.dout[DQ_TMO] = next_s.timeout_flag;
			next_s.dout[DQ_ESTART] = estart;
			next_s.dout[DQ_TOG2] = next_s.sector_toggle_bit;
			next_s.dout[DQ_ABORT] = next_s.buffer_abort_flag;
		end else begin
			next_s.dout = pins.array_data;
		end
		// ready only when idle or suspended
		next_s.rb_n = !next_s.overlay || (next_s.mode == M_ESUSP);
	end

	// all state in one register; clock enable freezes it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s.mode <= M_IDLE;
			s.from_buf <= 1'b0;
			s.timeout_flag <= 1'b0;
			s.buffer_abort_flag <= 1'b0;
			s.toggle_bit_one <= 1'b0;
			s.sector_toggle_bit <= 1'b0;
			s.cnt <= CNT_RST;
			s.dout <= DOUT_RST;
			s.overlay <= 1'b0;
			s.rb_n <= 1'b1;
			s.pready <= 1'b0;
			s.pslverr <= 1'b0;
			s.prdata <= PRDATA_RST;
		end else if (clk_en) begin
			s <= next_s;
		end
	end

	// outputs straight from the state register
	assign apb_rsp.pready = s.pready;
	assign apb_rsp.pslverr = s.pslverr;
	assign apb_rsp.prdata = s.prdata;
	assign data_out = s.dout;
	assign status_overlay = s.overlay;
	assign ready_busy_n = s.rb_n;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence seq_reset_taken;
		clk_en && cmd_we && op == OP_RESET && s.timeout_flag && toggling && s.mode != M_PROT;
	endsequence

	sequence seq_reset_busy;
		(!s.timeout_flag && !s.rb_n && s.mode == M_RSTBUSY) [*8];
	endsequence

	a_toggle_flips: assert property (clk_en && rd_end && toggling
		|=> s.toggle_bit_one != $past(s.toggle_bit_one)) else $error("toggle did not flip");
	a_suspend_static: assert property (clk_en && rd_end && s.mode == M_ESUSP
		|=> $stable(s.toggle_bit_one)) else $error("toggle moved in suspend");
	a_sector_toggle: assert property (clk_en && rd_end && !pins.in_erase_sector
		|=> $stable(s.sector_toggle_bit)) else $error("sector toggle outside sector");
	a_prot_entry: assert property (clk_en && s.mode == M_IDLE && cmd_we
		&& op == OP_ERASE && prot |=> s.mode == M_PROT && s.cnt == CNT_W'(PROT_CYCLES - 1))
		else $error("protected erase not timed");
	a_prot_exit: assert property (clk_en && s.mode == M_PROT && s.cnt == CNT_RST
		|=> s.mode == M_IDLE && !s.overlay) else $error("protected erase overstays");
	a_erase_ignore: assert property (clk_en && s.mode == M_ERASE && cmd_we
		&& (op == OP_PROG || op == OP_BUF || op == OP_ERASE)
		|=> s.mode == M_ERASE) else $error("command taken during erase");
	a_erase_word: assert property (clk_en && s.mode == M_ERASE
		&& next_s.mode == M_ERASE |=> !s.dout[DQ_POLL] && s.dout[DQ_ESTART] && !s.rb_n
		&& s.overlay && s.dout[DQ_TMO] == s.timeout_flag)
		else $error("bad erase status word");
	a_timeout_set: assert property (clk_en && toggling && s.mode != M_PROT
		&& cmd_we && op == OP_TIMEOUT |=> s.timeout_flag && s.dout[DQ_TMO] && !s.rb_n)
		else $error("timeout not shown");
	a_reset_clears: assert property (seq_reset_taken |=> seq_reset_busy)
		else $error("reset did not clear timeout");
	a_abort_flag: assert property (clk_en && s.mode == M_BUF && cmd_we
		&& op == OP_ABORT |=> s.buffer_abort_flag && s.dout[DQ_ABORT] && s.mode == M_BUF)
		else $error("abort flag missing");
	a_susp_ready: assert property (clk_en
		&& (next_s.mode == M_PSUSP || next_s.mode == M_ESUSP) |=> s.rb_n)
		else $error("suspend not ready");
	a_done_array: assert property (clk_en && s.mode == M_PROG && !s.timeout_flag
		&& cmd_we && op == OP_DONE |=> s.dout == $past(pins.array_data) && s.rb_n)
		else $error("no array data after done");
	a_poll_complement: assert property (clk_en && s.mode == M_PROG
		&& next_s.mode == M_PROG |=> s.dout[DQ_POLL] == !$past(pins.prog_data7))
		else $error("poll bit not inverted");
endmodule
`default_nettype wire

// ==== flash_embedded_status_polling_bench.sv ====
// self-checking bench for the status-polling block, random array data
// assumes the host model frames reads and this bench masters apb
`timescale 1ns/100ps
`default_nettype none
module flash_embedded_status_polling_bench
	import fesp_pkg::*;
;
	localparam int PC = 40;
	localparam logic [15:0] M = 16'hFFBB;
	localparam logic [15:0] ME = 16'hFFB3;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic ce_n, oe_n, done, rdy, ov, rerr;
	logic start = 1'b0, use_ce = 1'b0, ies = 1'b0, p7 = 1'b0, en = 1'b1;
	logic [15:0] arr = 16'h0000, dout, prev, last;
	logic [31:0] seed = 32'h0000_0024, rdata;
	int errors = 0, check_count = 0, cyc = 0;
	fesp_apb_req_t req = '0;
	fesp_apb_rsp_t rsp;
	fesp_pins_t pins;
	// write strobe held high: this bench only reads the data bus
	assign pins = {ce_n, oe_n, 1'b1, ies, arr, p7};
	fesp_top #(.PROT_CYCLES(PC)) i_fesp_top (.pclk(pclk), .presetn(presetn), .clk_en(en),
		.apb_req(req), .apb_rsp(rsp), .pins(pins), .data_out(dout), .status_overlay(ov),
		.ready_busy_n(rdy));
	fesp_host i_fesp_host (.pclk(pclk), .presetn(presetn), .start(start), .use_ce(use_ce),
		.chip_enable_n(ce_n), .output_enable_n(oe_n), .done(done));
	// free-running clock, 5 ns period
	initial begin
		forever #2.5 pclk = ~pclk;
	end
	task automatic conclude();
		if (errors == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// hang guard, well above the expected run of about eight hundred cycles
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			errors++;
			conclude();
		end
	end
	task automatic cmp_w(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t word got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmp_b(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t bit got %b exp %b", $time, got, exp);
		end
	endtask
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	endfunction
	// expected status word; toggle positions left zero, masked by caller
	function automatic logic [15:0] st(input logic poll, input logic tmo,
		input logic est, input logic abt);
		st = 16'h0000;
		st[DQ_POLL] = poll;
		st[DQ_TMO] = tmo;
		st[DQ_ESTART] = est;
		st[DQ_ABORT] = abt;
	endfunction
	// request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		int n;
		n = 0;
		req.psel <= 1'b1;
		req.pwrite <= w;
		req.paddr <= a;
		req.pwdata <= d;
		@(posedge pclk);
		req.penable <= 1'b1;
		@(posedge pclk);
		while (rsp.pready !== 1'b1 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		// a slave that never answers is a mismatch, not a silent pass
		if (n == 20) begin
			errors++;
			$display("ERROR %0t apb no ready", $time);
		end
		rdata = rsp.prdata;
		rerr = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		@(posedge pclk);
	endtask
	// command write, then fresh random array word and program bit
	task automatic cmd(input logic [3:0] op, input logic prot);
		apb(1'b1, ADDR_CMD, {23'h00_0000, prot, 4'h0, op});
		seed = xs(seed);
		arr <= seed[15:0];
		p7 <= seed[16];
		repeat (2) @(posedge pclk);
	endtask
	task automatic chk_mode(input fesp_mode_t m);
		apb(1'b0, ADDR_STATUS, 32'h0000_0000);
		cmp_w({28'h000_0000, rdata[11:8]}, 32'(m));
		cmp_b(rdata[ST_BUSY_BIT], m == M_ERASE);
		cmp_b(rdata[ST_ESTART_BIT], m == M_ERASE || m == M_ESUSP);
	endtask
	task automatic wait_rdy(input int lim);
		int n;
		n = 0;
		while (rdy !== 1'b1 && n < lim + 20) begin
			@(posedge pclk);
			n++;
		end
		cmp_b(n >= lim - 8 && n <= lim, 1'b1);
	endtask
	// one read cycle; sampled after the toggle update has reached data_out
	task automatic rd(input logic ce);
		int n;
		n = 0;
		use_ce <= ce;
		start <= 1'b1;
		@(posedge pclk);
		start <= 1'b0;
		while (done !== 1'b1 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		if (n == 20) begin
			errors++;
			$display("ERROR %0t read never ended", $time);
		end
		repeat (3) @(posedge pclk);
		prev = last;
		last = dout;
	endtask
	// double read, one framed by each strobe, as a polling host starts
	task automatic poll2(input logic [15:0] ew, input logic [15:0] m, input logic t1, input logic t2);
		rd(1'b0);
		rd(1'b1);
		cmp_w(last & m, ew & m);
		cmp_w(prev & m, ew & m);
		cmp_b(last[DQ_TOG1] ^ prev[DQ_TOG1], t1);
		cmp_b(last[DQ_TOG2] ^ prev[DQ_TOG2], t2);
	endtask
	// main sequence
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, 12'h008, 32'h0000_0000);
		cmp_b(rerr, 1'b1);
		poll2(arr, M, 1'b0, 1'b0);
		cmd(OP_PROG, 1'b0);
		cmp_b(rdy, 1'b0);
		cmp_b(ov, 1'b1);
		// frozen by the enable: reads leave the word and both toggles alone
		en <= 1'b0;
		rd(1'b0);
		rd(1'b1);
		cmp_w(last, prev);
		en <= 1'b1;
		poll2(st(~p7, 1'b0, 1'b0, 1'b0), ME, 1'b1, 1'b0);
		cmd(OP_DONE, 1'b0);
		poll2(arr, M, 1'b0, 1'b0);
		cmd(OP_PROG, 1'b0);
		cmd(OP_SUSP, 1'b0);
		poll2(arr, M, 1'b0, 1'b0);
		cmp_b(rdy, 1'b1);
		cmp_b(ov, 1'b0);
		cmd(OP_RESUME, 1'b0);
		cmd(OP_DONE, 1'b0);
		cmd(OP_ERASE, 1'b0);
		ies <= 1'b1;
		poll2(st(1'b0, 1'b0, 1'b1, 1'b0), M, 1'b1, 1'b1);
		ies <= 1'b0;
		poll2(st(1'b0, 1'b0, 1'b1, 1'b0), M, 1'b1, 1'b0);
		cmd(OP_BUF, 1'b0);
		chk_mode(M_ERASE);
		cmd(OP_SUSP, 1'b0);
		ies <= 1'b1;
		poll2(st(1'b1, 1'b0, 1'b1, 1'b0), ME, 1'b0, 1'b1);
		cmp_b(rdy, 1'b1);
		ies <= 1'b0;
		poll2(arr, M, 1'b0, 1'b0);
		cmd(OP_PROG, 1'b0);
		poll2(st(~p7, 1'b0, 1'b0, 1'b0), ME, 1'b1, 1'b0);
		cmp_b(rdy, 1'b0);
		cmd(OP_DONE, 1'b0);
		chk_mode(M_ESUSP);
		cmd(OP_RESUME, 1'b0);
		chk_mode(M_ERASE);
		cmd(OP_DONE, 1'b0);
		cmd(OP_ERASE, 1'b1);
		wait_rdy(PC);
		poll2(arr, M, 1'b0, 1'b0);
		cmd(OP_PROG, 1'b0);
		cmd(OP_TIMEOUT, 1'b0);
		poll2(st(~p7, 1'b1, 1'b0, 1'b0), ME, 1'b1, 1'b0);
		cmd(OP_DONE, 1'b0);
		cmp_b(rdy, 1'b0);
		cmd(OP_RESET, 1'b0);
		wait_rdy(RST_BUSY_CYC);
		poll2(arr, M, 1'b0, 1'b0);
		cmd(OP_BUF, 1'b0);
		poll2(st(~p7, 1'b0, 1'b0, 1'b0), ME, 1'b1, 1'b0);
		cmd(OP_ABORT, 1'b0);
		poll2(st(~p7, 1'b0, 1'b0, 1'b1), ME, 1'b1, 1'b0);
		cmd(OP_ABRST, 1'b0);
		poll2(arr, M, 1'b0, 1'b0);
		cmp_b(rdy, 1'b1);
		conclude();
	end
endmodule
`default_nettype wire
